// ===== core/ovl_cfg.svh
// Offsets, field positions and reset values of the overlay setup bank.
// Assumes byte addresses relative to the video processor base.
`ifndef OVL_CFG_SVH
`define OVL_CFG_SVH

`define OFS_COLOR_KEYS      8'h04
`define OFS_KEY_MASKS       8'h08
`define OFS_GFX_START       8'h0c
`define OFS_GFX_WIDTH_OFS   8'h10
`define OFS_WIN1_LEFT_TOP   8'h14
`define OFS_WIN1_RIGHT_BOT  8'h18
`define OFS_WIN1_START      8'h1c
`define OFS_WIN1_WIDTH_OFS  8'h20
`define OFS_CTRL            8'h40
`define OFS_STATUS          8'h44

`define PEND_BIT            19
`define KEY_ENABLE_BIT      0
`define KEY_16BIT_BIT       1

`define MASK_START          32'h0007_ffff
`define MASK_WIDTH_OFS      32'h03ff_03ff
`define MASK_BOUNDS         32'h07ff_07ff
`define MASK_KEY8           32'h00ff_00ff
`define MASK_CTRL           32'h0000_0003

`define RESET_WORD          32'h0000_0000

`endif

// ===== core/ovl_pkg.sv
// Types shared by the overlay setup bank.
// Assumes the constants of ovl_cfg.svh.
package ovl_pkg;

  typedef struct packed {
    logic [18:0] start;
    logic        pending;
  } frame_src_t;

  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
  } screen_pos_t;

  typedef struct packed {
    logic [23:0] gfx_pixel;
    logic [10:0] x;
    logic [10:0] y;
  } pixel_in_t;

endpackage

// ===== core/ovl_src_start.sv
// One frame source start register with its pending flag.
// Assumes a frame-start pulse from the display timing.
`timescale 1ns/100ps
`default_nettype none
`include "ovl_cfg.svh"

module ovl_src_start (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Software write
  input  wire logic                wr_en,
  input  wire logic [31:0]         wdata,
  // Frame timing
  input  wire logic                frame_start,
  // State
  output var  ovl_pkg::frame_src_t src_r
);

  ovl_pkg::frame_src_t src_nxt;

  // Set wins over the clear in the same cycle
  always_comb begin
    src_nxt = src_r;
    if (frame_start) begin
      src_nxt.pending = 1'b0;
    end
    if (wr_en) begin
      src_nxt.start   = wdata[18:0];
      src_nxt.pending = wdata[`PEND_BIT] | (src_r.pending & ~frame_start);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= '0;
    end else begin
      src_r <= src_nxt;
    end
  end

endmodule // ovl_src_start

`default_nettype wire

// ===== core/ovl_window_regs.sv
// Overlay window setup bank: APB registers plus per-pixel key compare.
// Assumes an APB master on pclk and display timing in the same domain.
//
// How it works
// - In 8-bit mode key bits 23:16 and 7:0 are the window II and I indices.
// - In 16-bit mode bits 31:16 key window II and bits 15:0 key window I.
// - Mask bits 31:16 and 15:0 enable masking per key bit for each window.
// - Graphics start address sits in bits 18:0 in 64-bit units.
// - Hardware clears the pending flag when a frame adopts the address.
// - The graphics pending flag reads 1 while the address waits for use.
// - Graphics line width sits in bits 25:16 in 64-bit units.
// - Graphics line offset sits in bits 9:0 in 64-bit units.
// - Window I top is bits 26:16 and left is bits 10:0 of one register.
// - Window I bottom is bits 26:16 and right is bits 10:0 of another.
// - Window I start address is bits 18:0 with its own pending flag.
// - Window I line width is bits 25:16 and offset bits 9:0.
// - Window I keying acts only while the key enable bit is set.
`timescale 1ns/100ps
`default_nettype none
`include "ovl_cfg.svh"

module ovl_window_regs (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Display timing
  input  wire logic                frame_start,
  input  wire ovl_pkg::pixel_in_t  pix_in,
  // Overlay decision
  output var  logic                show_video_r,
  // Frame fetch setup
  output var  logic [18:0]         gfx_frame_start,
  output var  logic [18:0]         win1_frame_start,
  output var  logic [31:0]         gfx_width_ofs,
  output var  logic [31:0]         win1_width_ofs
);

  // Stored words
  logic [31:0] color_keys_r;
  logic [31:0] key_masks_r;
  logic [31:0] gfx_lwo_r;
  logic [31:0] win1_lt_r;
  logic [31:0] win1_rb_r;
  logic [31:0] win1_lwo_r;
  logic [31:0] ctrl_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  ovl_pkg::frame_src_t gfx_src;
  ovl_pkg::frame_src_t win1_src;

  // Decode
  wire access    = psel & penable;
  wire wr        = access & pwrite;
  wire hit_key   = (paddr == `OFS_COLOR_KEYS);
  wire hit_mask  = (paddr == `OFS_KEY_MASKS);
  wire hit_gst   = (paddr == `OFS_GFX_START);
  wire hit_glwo  = (paddr == `OFS_GFX_WIDTH_OFS);
  wire hit_lt    = (paddr == `OFS_WIN1_LEFT_TOP);
  wire hit_rb    = (paddr == `OFS_WIN1_RIGHT_BOT);
  wire hit_wst   = (paddr == `OFS_WIN1_START);
  wire hit_wlwo  = (paddr == `OFS_WIN1_WIDTH_OFS);
  wire hit_ctrl  = (paddr == `OFS_CTRL);
  wire hit_stat  = (paddr == `OFS_STATUS);
  wire hit_any   = hit_key | hit_mask | hit_gst | hit_glwo | hit_lt |
                   hit_rb | hit_wst | hit_wlwo | hit_ctrl | hit_stat;

  // Key width follows the control bit; 8-bit mode drops reserved bits
  wire         mode16    = ctrl_r[`KEY_16BIT_BIT];
  wire [31:0]  key_wmask = mode16 ? 32'hffff_ffff : `MASK_KEY8;

  // Pending flags live in the start registers
  ovl_src_start u_gfx_src (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (wr & hit_gst),
    .wdata       (pwdata),
    .frame_start (frame_start),
    .src_r       (gfx_src)
  );

  ovl_src_start u_win1_src (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (wr & hit_wst),
    .wdata       (pwdata),
    .frame_start (frame_start),
    .src_r       (win1_src)
  );

  wire [31:0] gst_word  = {12'h000, gfx_src.pending, gfx_src.start};
  wire [31:0] wst_word  = {12'h000, win1_src.pending, win1_src.start};
  wire [31:0] stat_word = {30'h0000_0000, win1_src.pending,
                           gfx_src.pending};

  // Read mux; unmapped reads return zero
  wire [31:0] rd_word =
      hit_key  ? color_keys_r :
      hit_mask ? key_masks_r  :
      hit_gst  ? gst_word     :
      hit_glwo ? gfx_lwo_r    :
      hit_lt   ? win1_lt_r    :
      hit_rb   ? win1_rb_r    :
      hit_wst  ? wst_word     :
      hit_wlwo ? win1_lwo_r   :
      hit_ctrl ? ctrl_r       :
      hit_stat ? stat_word    : `RESET_WORD;

  // Registers clear at reset though software must not rely on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      color_keys_r <= `RESET_WORD;
      key_masks_r  <= `RESET_WORD;
      gfx_lwo_r    <= `RESET_WORD;
      win1_lt_r    <= `RESET_WORD;
      win1_rb_r    <= `RESET_WORD;
      win1_lwo_r   <= `RESET_WORD;
      ctrl_r       <= `RESET_WORD;
    end else if (wr) begin
      if (hit_key)  color_keys_r <= pwdata & key_wmask;
      if (hit_mask) key_masks_r  <= pwdata;
      if (hit_glwo) gfx_lwo_r    <= pwdata & `MASK_WIDTH_OFS;
      if (hit_lt)   win1_lt_r    <= pwdata & `MASK_BOUNDS;
      if (hit_rb)   win1_rb_r    <= pwdata & `MASK_BOUNDS;
      if (hit_wlwo) win1_lwo_r   <= pwdata & `MASK_WIDTH_OFS;
      if (hit_ctrl) ctrl_r       <= pwdata & `MASK_CTRL;
    end
  end

  // Zero-wait answer in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= `RESET_WORD;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (psel & ~penable & ~pwrite) ? rd_word : prdata_r;
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~hit_any;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Key compare for window I; 8-bit mode compares the index only
  // 8-bit mode keys by index alone, whatever was left in bits 15:8
  wire [15:0] key1   = mode16 ? color_keys_r[15:0]
                              : {8'h00, color_keys_r[7:0]};
  wire [15:0] mask1  = key_masks_r[15:0];
  wire [15:0] pix16  = mode16 ? pix_in.gfx_pixel[15:0]
                              : {8'h00, pix_in.gfx_pixel[7:0]};
  // A set mask bit removes that bit from the compare
  wire        key_eq = ((pix16 ^ key1) & ~mask1) == 16'h0000;
  wire        in_x   = (pix_in.x >= win1_lt_r[10:0]) &
                       (pix_in.x <= win1_rb_r[10:0]);
  wire        in_y   = (pix_in.y >= win1_lt_r[26:16]) &
                       (pix_in.y <= win1_rb_r[26:16]);
  wire        key_on = ctrl_r[`KEY_ENABLE_BIT];
  // Keying off means the whole rectangle shows video
  wire        vid    = in_x & in_y & (~key_on | key_eq);

  logic [18:0] gfx_fs_r;
  logic [18:0] win1_fs_r;
  logic [31:0] gfx_wo_q;
  logic [31:0] win1_wo_q;

  // Outputs registered; start address is latched at frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_video_r <= 1'b0;
      gfx_fs_r     <= 19'h00000;
      win1_fs_r    <= 19'h00000;
      gfx_wo_q     <= `RESET_WORD;
      win1_wo_q    <= `RESET_WORD;
    end else begin
      show_video_r <= vid;
      gfx_wo_q     <= gfx_lwo_r;
      win1_wo_q    <= win1_lwo_r;
      if (frame_start) begin
        gfx_fs_r  <= gfx_src.start;
        win1_fs_r <= win1_src.start;
      end
    end
  end

  assign gfx_frame_start  = gfx_fs_r;
  assign win1_frame_start = win1_fs_r;
  assign gfx_width_ofs    = gfx_wo_q;
  assign win1_width_ofs   = win1_wo_q;

endmodule // ovl_window_regs

`default_nettype wire

// ===== tb/ovl_window_regs_props.sv
// Port checker for the overlay setup bank.
// Assumes one pclk domain and the APB timing of the design.
`timescale 1ns/100ps
`default_nettype none
module ovl_window_regs_props (
  // Clock, reset and bus controls
  input wire logic               pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata, prdata,
  input wire logic               pready, pslverr,
  // Display side
  input wire logic               frame_start, show_video_r,
  input wire ovl_pkg::pixel_in_t pix_in,
  input wire logic [18:0]        gfx_frame_start, win1_frame_start,
  input wire logic [31:0]        gfx_width_ofs, win1_width_ofs
);
  wire logic rd = psel && penable && pready && !pwrite;
  wire logic wr = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_ans; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_gfx_hold; !frame_start |=> $stable(gfx_frame_start); endproperty
  property p_win1_hold; !frame_start |=> $stable(win1_frame_start); endproperty
  property p_gfx_rsv; rd && paddr == 8'h0c |-> prdata[31:20] == 12'h000;
  endproperty
  property p_wo_rsv; rd && (paddr == 8'h10 || paddr == 8'h20)
    |-> (prdata & 32'hfc00_fc00) == 32'h0000_0000; endproperty
  property p_bnd_rsv; rd && (paddr == 8'h14 || paddr == 8'h18)
    |-> (prdata & 32'hf800_f800) == 32'h0000_0000; endproperty
  // Copy trails the register by one cycle
  property p_wo_copy; wr && paddr == 8'h10
    |=> ##1 gfx_width_ofs == ($past(pwdata, 2) & 32'h03ff_03ff); endproperty
  a_ready_ans: assert property (p_ready_ans) else $error("no pready");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  a_gfx_hold: assert property (p_gfx_hold) else $error("gfx moved");
  a_win1_hold: assert property (p_win1_hold) else $error("win moved");
  a_gfx_rsv: assert property (p_gfx_rsv) else $error("gfx rsv");
  a_wo_rsv: assert property (p_wo_rsv) else $error("width rsv");
  a_bnd_rsv: assert property (p_bnd_rsv) else $error("bound rsv");
  a_wo_copy: assert property (p_wo_copy) else $error("copy wrong");
  c_adopt: cover property (frame_start ##1 pready);
  c_video: cover property ($rose(show_video_r));
  c_err: cover property (pslverr);
endmodule // ovl_window_regs_props
bind ovl_window_regs ovl_window_regs_props u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .frame_start, .show_video_r, .pix_in, .gfx_frame_start,
  .win1_frame_start, .gfx_width_ofs, .win1_width_ofs);
`default_nettype wire

// ===== tb/ovl_window_regs_test.sv
// Self-checking bench for the overlay setup bank.
// Assumes zero-wait APB answers and a one-cycle key compare.
`timescale 1ns/100ps
`default_nettype none
module ovl_window_regs_test;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic               pwrite = 0, pready, pslverr, frame_start = 0, err;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, r, gwo, wwo;
  logic               show_video_r;
  ovl_pkg::pixel_in_t pix_in = '0;
  logic [18:0]        gfs, wfs;
  int                 n_fail = 0, checks = 0;
  ovl_window_regs u_ovl_window_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .pix_in(pix_in),
    .show_video_r(show_video_r), .gfx_frame_start(gfs),
    .win1_frame_start(wfs), .gfx_width_ofs(gwo), .win1_width_ofs(wwo));
  always #50 pclk = ~pclk;
  task automatic wrap_up;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bounded wait: a silent slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin n_fail++; wrap_up(); end
    r = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] e);
    apb(1, a, 32'hffff_ffff); apb(0, a, 0); chk(r, e);
  endtask
  task automatic t_regs;
    apb(1, 8'h40, 0); rw(8'h04, 32'h00ff_00ff);
    apb(1, 8'h40, 2); rw(8'h04, 32'hffff_ffff);
    rw(8'h08, 32'hffff_ffff);
    rw(8'h0c, 32'h000f_ffff); rw(8'h1c, 32'h000f_ffff);
    rw(8'h10, 32'h03ff_03ff); chk(gwo, 32'h03ff_03ff);
    rw(8'h20, 32'h03ff_03ff); chk(wwo, 32'h03ff_03ff);
    rw(8'h14, 32'h07ff_07ff); rw(8'h18, 32'h07ff_07ff);
    rw(8'h3c, 0); chk({31'h0, err}, 1);
    $display("t_regs done");
  endtask
  task automatic t_pend(input logic [7:0] a, input logic [18:0] s);
    apb(1, a, {12'h0, 1'b1, s});
    apb(0, a, 0); chk(r, {12'h0, 1'b1, s});
    @(posedge pclk); frame_start <= 1;
    @(posedge pclk); frame_start <= 0;
    apb(0, a, 0); chk(r, {13'h0, s});
    chk({13'h0, a == 8'h0c ? gfs : wfs}, {13'h0, s});
    $display("t_pend done");
  endtask
  // Write with the flag set lands on the edge of a frame start
  task automatic t_race;
    fork
      apb(1, 8'h0c, {12'h0, 1'b1, 19'h00055});
      begin
        repeat (2) @(posedge pclk);
        frame_start <= 1;
        @(posedge pclk);
        frame_start <= 0;
      end
    join
    apb(0, 8'h0c, 0); chk(r, {12'h0, 1'b1, 19'h00055});
    chk({13'h0, gfs}, {13'h0, 19'h01234});
    $display("t_race done");
  endtask
  task automatic px(input logic [10:0] x, y, input logic [23:0] p, logic e);
    @(posedge pclk); pix_in <= '{p, x, y};
    @(posedge pclk); @(negedge pclk); chk({31'h0, show_video_r}, {31'h0, e});
  endtask
  task automatic t_key;
    apb(1, 8'h14, 32'h0005_000a); apb(1, 8'h18, 32'h0008_0014);
    apb(1, 8'h40, 3); apb(1, 8'h04, 32'h0000_1234);
    apb(1, 8'h08, 32'h0000_000f);
    px(20, 8, 24'h00_123b, 1);
    px(20, 8, 24'h00_1334, 0);
    px(21, 8, 24'h00_1234, 0);
    px(10, 4, 24'h00_1234, 0);
    apb(1, 8'h40, 2); px(10, 5, 24'h00_0000, 1);
    apb(1, 8'h40, 1); px(10, 5, 24'h00_ab3b, 1);
    px(10, 5, 24'h00_0044, 0);
    $display("t_key done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_regs(); t_pend(8'h0c, 19'h01234); t_pend(8'h1c, 19'h40abc);
    t_race(); t_key();
    wrap_up();
  end
endmodule // ovl_window_regs_test
`default_nettype wire
